// File: cms_pkg.sv
// shared constants, enumerations and carrier types of the configuration mode sequencer
package cms_pkg;

	// timing
	localparam int unsigned CLK_FREQ_MHZ   = 20;
	localparam int unsigned POR_TIME_US    = 50;
	// product of time and clock rate, held to at least one cycle
	localparam int unsigned POR_CYCLES     = (POR_TIME_US * CLK_FREQ_MHZ < 1) ? 1 :
		POR_TIME_US * CLK_FREQ_MHZ;
	localparam int unsigned POR_CNT_W      = 11;
	localparam int unsigned RECONF_TIME_MS = 320;
	localparam int unsigned SHIFT_CLK_MHZ  = 10;
	// most configuration bits a full reload may carry at the nominal shift clock
	localparam longint unsigned RECONF_MAX_BITS =
		longint'(RECONF_TIME_MS) * 64'd1000 * longint'(SHIFT_CLK_MHZ);

	// data widths and counts
	localparam int unsigned BYTE_W         = 8;
	localparam int unsigned WORD_W         = 64;
	localparam int unsigned BIT_CNT_W      = 7;
	localparam int unsigned BYTE_CNT_W     = 4;
	localparam int unsigned INIT_CYCLES    = 4;
	localparam int unsigned CONFIG_WORDS   = 64;

	// loading schemes, caught from the scheme pins when power-on clear ends
	typedef enum logic [2:0] {
		CMS_SCH_CFG_MEM = 3'h0,
		CMS_SCH_SERIAL  = 3'h1,
		CMS_SCH_PAR_ASY = 3'h2,
		CMS_SCH_PAR_SYN = 3'h3,
		CMS_SCH_BSCAN   = 3'h4
	} cms_scheme_t;

	typedef enum logic [2:0] {
		CMS_ST_POR  = 3'h0,
		CMS_ST_WAIT = 3'h1,
		CMS_ST_LOAD = 3'h2,
		CMS_ST_INIT = 3'h3,
		CMS_ST_USER = 3'h4
	} cms_state_t;

	// link-side state, clocked by the configuration shift clock
	typedef struct packed {
		logic                  rst_s1;
		logic                  rst_s2;
		logic                  ser_s1;
		logic                  ser_s2;
		logic                  par_s1;
		logic                  par_s2;
		logic [WORD_W-1:0]     shift;
		logic [BIT_CNT_W-1:0]  bits;
		logic [WORD_W-1:0]     word;
		logic                  toggle;
	} cms_link_t;

endpackage

// File: cms_cfg_mem.sv
// configuration storage, volatile: contents are meaningful only after a load
`timescale 1ns/100ps
`default_nettype none

module cms_cfg_mem #(
	parameter int unsigned WIDTH = 64,
	parameter int unsigned DEPTH = 64,
	parameter int unsigned AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_resetn,
	// write port
	input  wire logic             i_wr_en,
	input  wire logic [AW-1:0]    i_wr_addr,
	input  wire logic [WIDTH-1:0] i_wr_data,
	// read port
	input  wire logic [AW-1:0]    i_rd_addr,
	output logic      [WIDTH-1:0] o_rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	initial
	begin
		if (DEPTH < 2 || AW != $clog2(DEPTH))
			$error("cms_cfg_mem: bad depth or address width");
	end

	// no reset on the array: storage holds nothing until loaded
	always_ff @(posedge i_clock)
	begin
		if (i_wr_en)
			mem[i_wr_addr] <= i_wr_data;
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			o_rd_data <= '0;
		else
			o_rd_data <= mem[i_rd_addr];
	end

endmodule

`default_nettype wire

// File: cms_config_mode_sequencer.sv
// power-up and configuration mode sequencer with serial and parallel loaders
`timescale 1ns/100ps
`default_nettype none

module cms_config_mode_sequencer #(
	parameter int unsigned CONFIG_WORDS = cms_pkg::CONFIG_WORDS,
	parameter int unsigned INIT_CYCLES  = cms_pkg::INIT_CYCLES,
	parameter int unsigned AW           = $clog2(CONFIG_WORDS)
) (
	// system clock and reset
	input  wire logic                        I_CLOCK,
	input  wire logic                        I_RESETN,
	// configuration link
	input  wire logic                        I_CONFIG_SHIFT_CLOCK,
	input  wire logic                        I_SERIAL_DATA,
	input  wire logic [cms_pkg::BYTE_W-1:0]  I_PARALLEL_DATA,
	input  wire logic                        I_PARALLEL_STROBE_N,
	// control pins
	input  wire logic [2:0]                  I_SCHEME,
	input  wire logic                        I_RECONFIG_N,
	input  wire logic                        I_CHAIN_ENABLE_IN_N,
	output logic                             O_CHAIN_ENABLE_OUT_N,
	// status
	output logic                             O_COMMAND_MODE,
	output logic                             O_USER_MODE,
	output logic                             O_CONFIG_DONE,
	output logic                             O_READY_FOR_DATA,
	// user side
	output logic                             O_USER_RESET_N,
	output logic                             O_IO_OE_N,
	input  wire logic [AW-1:0]               I_CFG_RD_ADDR,
	output logic      [cms_pkg::WORD_W-1:0]  O_CFG_RD_DATA
);

	typedef struct packed {
		cms_pkg::cms_state_t               fsm;
		cms_pkg::cms_scheme_t              scheme;
		logic [cms_pkg::POR_CNT_W-1:0]     por_cnt;
		logic [7:0]                        init_cnt;
		logic [AW:0]                       word_cnt;
		logic                              done;
		logic [2:0]                        sch_s1;
		logic [2:0]                        sch_s2;
		logic                              rcfg_s1;
		logic                              rcfg_s2;
		logic                              cen_s1;
		logic                              cen_s2;
		logic                              tog_s1;
		logic                              tog_s2;
		logic                              tog_s3;
		logic                              stb_s1;
		logic                              stb_s2;
		logic                              stb_s3;
		logic [cms_pkg::BYTE_W-1:0]        pd_s1;
		logic [cms_pkg::BYTE_W-1:0]        pd_s2;
		logic [cms_pkg::WORD_W-1:0]        pack;
		logic [cms_pkg::BYTE_CNT_W-1:0]    pack_cnt;
	} cms_core_t;

	localparam int unsigned BYTES_PER_WORD = cms_pkg::WORD_W / cms_pkg::BYTE_W;

	cms_core_t         st;
	cms_core_t         next_st;
	cms_pkg::cms_link_t lk;
	cms_pkg::cms_link_t next_lk;

	logic                        wr_en;
	logic [cms_pkg::WORD_W-1:0]  wr_data;
	logic                        link_serial;
	logic                        link_parallel;
	logic                        link_word;
	logic                        asy_byte;

	initial
	begin
		if (CONFIG_WORDS < 2 || INIT_CYCLES < 1 || INIT_CYCLES > 255 ||
			AW != $clog2(CONFIG_WORDS))
			$error("cms_config_mode_sequencer: unsupported parameters");
		if (longint'(CONFIG_WORDS) * cms_pkg::WORD_W > cms_pkg::RECONF_MAX_BITS)
			$error("cms_config_mode_sequencer: image too large for reload time");
	end

	function automatic logic is_serial(input cms_pkg::cms_scheme_t s);
		is_serial = (s == cms_pkg::CMS_SCH_CFG_MEM) || (s == cms_pkg::CMS_SCH_SERIAL) ||
			(s == cms_pkg::CMS_SCH_BSCAN);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// link domain: words assembled on the source's shift clock

	// levels to the link side; scheme is static while loading so level crossing is safe
	assign link_serial   = (st.fsm == cms_pkg::CMS_ST_LOAD) && !st.cen_s2 && is_serial(st.scheme);
	assign link_parallel = (st.fsm == cms_pkg::CMS_ST_LOAD) && !st.cen_s2 &&
		(st.scheme == cms_pkg::CMS_SCH_PAR_SYN);

	always_comb
	begin
		next_lk        = lk;
		next_lk.rst_s1 = I_RESETN;
		next_lk.rst_s2 = lk.rst_s1;
		next_lk.ser_s1 = link_serial;
		next_lk.ser_s2 = lk.ser_s1;
		next_lk.par_s1 = link_parallel;
		next_lk.par_s2 = lk.par_s1;
		if (!lk.rst_s2)
		begin
			next_lk.shift  = '0;
			next_lk.bits   = '0;
			next_lk.word   = '0;
			next_lk.toggle = 1'b0;
		end
		else if (lk.ser_s2 || lk.par_s2)
		begin
			// data sampled on the rising shift clock edge
			if (lk.ser_s2)
			begin
				next_lk.shift = {lk.shift[cms_pkg::WORD_W-2:0], I_SERIAL_DATA};
				next_lk.bits  = lk.bits + 7'h01;
			end
			else
			begin
				next_lk.shift = {lk.shift[cms_pkg::WORD_W-cms_pkg::BYTE_W-1:0],
					I_PARALLEL_DATA};
				next_lk.bits  = lk.bits + 7'h08;
			end
			if (next_lk.bits == 7'(cms_pkg::WORD_W))
			begin
				// word stays put for a whole word time, long enough for the toggle to cross
				next_lk.word   = next_lk.shift;
				next_lk.bits   = '0;
				next_lk.toggle = !lk.toggle;
			end
		end
		else
		begin
			next_lk.shift = '0;
			next_lk.bits  = '0;
		end
	end

	always_ff @(posedge I_CONFIG_SHIFT_CLOCK)
	begin
		lk <= next_lk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// core domain: power-on clear, loading, initialization, user mode

	assign link_word = st.tog_s2 ^ st.tog_s3;
	assign asy_byte  = !st.stb_s2 && st.stb_s3;

	always_comb
	begin
		next_st          = st;
		wr_en            = 1'b0;
		wr_data          = lk.word;
		next_st.sch_s1   = I_SCHEME;
		next_st.sch_s2   = st.sch_s1;
		next_st.rcfg_s1  = I_RECONFIG_N;
		next_st.rcfg_s2  = st.rcfg_s1;
		next_st.cen_s1   = I_CHAIN_ENABLE_IN_N;
		next_st.cen_s2   = st.cen_s1;
		next_st.tog_s1   = lk.toggle;
		next_st.tog_s2   = st.tog_s1;
		next_st.tog_s3   = st.tog_s2;
		next_st.stb_s1   = I_PARALLEL_STROBE_N;
		next_st.stb_s2   = st.stb_s1;
		next_st.stb_s3   = st.stb_s2;
		next_st.pd_s1    = I_PARALLEL_DATA;
		next_st.pd_s2    = st.pd_s1;
		case (st.fsm)
			cms_pkg::CMS_ST_POR:
			begin
				next_st.por_cnt = st.por_cnt + 11'h001;
				if (st.por_cnt == 11'(cms_pkg::POR_CYCLES - 1))
				begin
					next_st.scheme = cms_pkg::cms_scheme_t'(st.sch_s2);
					next_st.fsm    = cms_pkg::CMS_ST_WAIT;
				end
			end
			cms_pkg::CMS_ST_WAIT:
			begin
				next_st.word_cnt = '0;
				next_st.pack_cnt = '0;
				next_st.done     = 1'b0;
				if (st.rcfg_s2)
					next_st.fsm = cms_pkg::CMS_ST_LOAD;
			end
			cms_pkg::CMS_ST_LOAD:
			begin
				// a chained device sees nothing until its turn
				if (!st.cen_s2)
				begin
					if (st.scheme == cms_pkg::CMS_SCH_PAR_ASY)
					begin
						if (asy_byte)
						begin
							next_st.pack = {st.pack[cms_pkg::WORD_W-cms_pkg::BYTE_W-1:0],
								st.pd_s2};
							next_st.pack_cnt = st.pack_cnt + 4'h1;
							if (st.pack_cnt == 4'(BYTES_PER_WORD - 1))
							begin
								wr_en            = 1'b1;
								wr_data          = next_st.pack;
								next_st.pack_cnt = '0;
							end
						end
					end
					else
						wr_en = link_word;
				end
				if (wr_en)
				begin
					next_st.word_cnt = st.word_cnt + 1'b1;
					if (st.word_cnt == (AW+1)'(CONFIG_WORDS - 1))
					begin
						next_st.done     = 1'b1;
						next_st.init_cnt = '0;
						next_st.fsm      = cms_pkg::CMS_ST_INIT;
					end
				end
			end
			cms_pkg::CMS_ST_INIT:
			begin
				next_st.init_cnt = st.init_cnt + 8'h01;
				if (st.init_cnt == 8'(INIT_CYCLES - 1))
					next_st.fsm = cms_pkg::CMS_ST_USER;
			end
			cms_pkg::CMS_ST_USER:
			begin
			end
			default:
				next_st.fsm = cms_pkg::CMS_ST_POR;
		endcase
		// reconfiguration pin wins over everything once power-on clear is over
		if (!st.rcfg_s2 && st.fsm != cms_pkg::CMS_ST_POR)
		begin
			next_st.fsm  = cms_pkg::CMS_ST_WAIT;
			next_st.done = 1'b0;
		end
	end

	always_ff @(posedge I_CLOCK)
	begin
		if (!I_RESETN)
		begin
			st         <= '0;
			st.fsm     <= cms_pkg::CMS_ST_POR;
			st.scheme  <= cms_pkg::CMS_SCH_CFG_MEM;
			st.rcfg_s1 <= 1'b1;
			st.rcfg_s2 <= 1'b1;
			st.cen_s1  <= 1'b1;
			st.cen_s2  <= 1'b1;
			st.stb_s1  <= 1'b1;
			st.stb_s2  <= 1'b1;
			st.stb_s3  <= 1'b1;
		end
		else
			st <= next_st;
	end

	cms_cfg_mem #(
		.WIDTH     (cms_pkg::WORD_W),
		.DEPTH     (CONFIG_WORDS),
		.AW        (AW)
	) u_mem (
		.i_clock   (I_CLOCK),
		.i_resetn  (I_RESETN),
		.i_wr_en   (wr_en),
		.i_wr_addr (st.word_cnt[AW-1:0]),
		.i_wr_data (wr_data),
		.i_rd_addr (I_CFG_RD_ADDR),
		.o_rd_data (O_CFG_RD_DATA)
	);

	assign O_USER_MODE          = (st.fsm == cms_pkg::CMS_ST_USER);
	assign O_COMMAND_MODE       = !O_USER_MODE;
	assign O_CONFIG_DONE        = st.done;
	assign O_READY_FOR_DATA     = (st.fsm == cms_pkg::CMS_ST_LOAD) && !st.cen_s2;
	assign O_USER_RESET_N       = O_USER_MODE;
	assign O_IO_OE_N            = !O_USER_MODE;
	assign O_CHAIN_ENABLE_OUT_N = !st.done;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	property p_io_tristate;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		(st.fsm != cms_pkg::CMS_ST_USER) |-> O_IO_OE_N && !O_USER_RESET_N;
	endproperty
	a_io_tristate: assert property (p_io_tristate)
		else $error("I/O enabled outside user mode");

	property p_por_bound;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		(st.fsm == cms_pkg::CMS_ST_POR && st.por_cnt == 11'(cms_pkg::POR_CYCLES - 1))
		|=> st.fsm != cms_pkg::CMS_ST_POR;
	endproperty
	a_por_bound: assert property (p_por_bound)
		else $error("power-on clear overran its limit");

	property p_por_clear;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		(st.fsm == cms_pkg::CMS_ST_POR) |-> st.word_cnt == '0 && !st.done && O_IO_OE_N;
	endproperty
	a_por_clear: assert property (p_por_clear)
		else $error("state not cleared during power-on clear");

	property p_init_len;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		($rose(st.fsm == cms_pkg::CMS_ST_INIT) && st.rcfg_s2)
		|-> (st.fsm == cms_pkg::CMS_ST_INIT) [*4] ##1
			(st.fsm == cms_pkg::CMS_ST_USER || !$past(st.rcfg_s2));
	endproperty
	a_init_len: assert property (p_init_len)
		else $error("initialization length wrong");

	property p_user_after_init;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		$rose(O_USER_MODE) |-> $past(st.fsm) == cms_pkg::CMS_ST_INIT && O_CONFIG_DONE;
	endproperty
	a_user_after_init: assert property (p_user_after_init)
		else $error("user mode entered without load and initialization");

	property p_reconfig;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		(!st.rcfg_s2 && st.fsm != cms_pkg::CMS_ST_POR)
		|=> st.fsm == cms_pkg::CMS_ST_WAIT && O_COMMAND_MODE && O_CHAIN_ENABLE_OUT_N;
	endproperty
	a_reconfig: assert property (p_reconfig)
		else $error("reconfigure pin did not force command mode");

	property p_chain_ignore;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		(st.cen_s2 && st.fsm == cms_pkg::CMS_ST_LOAD) |=> $stable(st.word_cnt);
	endproperty
	a_chain_ignore: assert property (p_chain_ignore)
		else $error("data taken while chain enable inactive");

	property p_chain_out;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		$fell(O_CHAIN_ENABLE_OUT_N) |-> $past(st.word_cnt) == (AW+1)'(CONFIG_WORDS - 1)
			&& $past(wr_en);
	endproperty
	a_chain_out: assert property (p_chain_out)
		else $error("chain enable out asserted before own load finished");

	property p_word_count;
		@(posedge I_CLOCK) disable iff (!I_RESETN)
		(wr_en && st.rcfg_s2) |=> st.word_cnt == $past(st.word_cnt) + 1'b1;
	endproperty
	a_word_count: assert property (p_word_count)
		else $error("accepted word not counted");

endmodule

`default_nettype wire

// File: cms_source_model.sv
// configuration source model: drives the link pins of the sequencer
`timescale 1ns/100ps
`default_nettype none

module cms_source_model (
	// link pins
	output logic                       o_shift_clock,
	output logic                       o_serial_data,
	output logic [cms_pkg::BYTE_W-1:0] o_parallel_data,
	output logic                       o_strobe_n
);
	localparam int HALF = 16;

	initial
	begin
		o_shift_clock = 1'b0;
		o_serial_data = 1'b0;
		o_parallel_data = 8'h00;
		o_strobe_n = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// data set while the clock is low, so the rising edge finds it settled
	task automatic tick();
		#HALF;
		o_shift_clock = 1'b1;
		#HALF;
		o_shift_clock = 1'b0;
	endtask

	// idle clocks with a changing data pattern, so nothing stale can be taken
	task automatic pulse(input int n);
		for (int i = 0; i < n; i++)
		begin
			o_serial_data = ~o_serial_data;
			o_parallel_data = ~o_parallel_data;
			tick();
		end
	endtask

	task automatic send(input logic [2:0] scheme, input logic [63:0] w);
		case (scheme)
			3'h3:
				for (int i = 0; i < 8; i++)
				begin
					o_parallel_data = w[63 - 8 * i -: 8];
					tick();
				end
			3'h2:
				for (int i = 0; i < 8; i++)
				begin
					o_parallel_data = w[63 - 8 * i -: 8];
					o_strobe_n = 1'b0;
					#200;
					o_strobe_n = 1'b1;
					#200;
				end
			default:
				for (int i = 0; i < 64; i++)
				begin
					o_serial_data = w[63 - i];
					tick();
				end
		endcase
		// released lines must not keep showing the last value
		o_serial_data = ~o_serial_data;
		o_parallel_data = ~o_parallel_data;
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking testbench of the configuration mode sequencer
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp, msg) \
	comparisons++; \
	if ((got) !== (exp)) \
	begin \
		n_mismatch++; \
		$display("wrong value at %0t: %s", $time, msg); \
	end

module testbench;
	localparam int WORDS = 4;
	logic       I_CLOCK = 1'b0;
	logic       I_RESETN;
	logic [2:0] I_SCHEME;
	logic       I_RECONFIG_N;
	logic       I_CHAIN_ENABLE_IN_N;
	logic [1:0] I_CFG_RD_ADDR;
	logic       shift_clock, serial_data, strobe_n;
	logic [7:0] parallel_data;
	logic       chain_out_n, command_mode, user_mode, config_done, ready, user_reset_n, io_oe_n;
	logic [63:0] rd_data;
	int         n_mismatch = 0;
	int         comparisons = 0;
	int         n;

	always #25 I_CLOCK = ~I_CLOCK;

	cms_source_model i_src (
		.o_shift_clock   (shift_clock),
		.o_serial_data   (serial_data),
		.o_parallel_data (parallel_data),
		.o_strobe_n      (strobe_n)
	);

	cms_config_mode_sequencer #(.CONFIG_WORDS(WORDS)) i_dut (
		.I_CLOCK              (I_CLOCK),
		.I_RESETN             (I_RESETN),
		.I_CONFIG_SHIFT_CLOCK (shift_clock),
		.I_SERIAL_DATA        (serial_data),
		.I_PARALLEL_DATA      (parallel_data),
		.I_PARALLEL_STROBE_N  (strobe_n),
		.I_SCHEME             (I_SCHEME),
		.I_RECONFIG_N         (I_RECONFIG_N),
		.I_CHAIN_ENABLE_IN_N  (I_CHAIN_ENABLE_IN_N),
		.O_CHAIN_ENABLE_OUT_N (chain_out_n),
		.O_COMMAND_MODE       (command_mode),
		.O_USER_MODE          (user_mode),
		.O_CONFIG_DONE        (config_done),
		.O_READY_FOR_DATA     (ready),
		.O_USER_RESET_N       (user_reset_n),
		.O_IO_OE_N            (io_oe_n),
		.I_CFG_RD_ADDR        (I_CFG_RD_ADDR),
		.O_CFG_RD_DATA        (rd_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("tests done: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge I_CLOCK);
		#1;
	endtask

	function automatic logic probe(input int sel);
		return (sel == 0) ? ready : (sel == 1) ? config_done : user_mode;
	endfunction

	task automatic wait_on(input int sel, input int max, output int cnt);
		cnt = 0;
		while (probe(sel) !== 1'b1)
		begin
			if (cnt == max)
			begin
				n_mismatch++;
				$display("wrong value at %0t: wait ran out", $time);
				end_sim();
			end
			cyc(1);
			cnt++;
		end
	endtask

	// byte pattern differs per position, so order slips show
	function automatic logic [63:0] img(input logic [31:0] base, input int w);
		return {base, ~base} ^ {8{8'(w + 1)}};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// the link needs edges during reset to clear its own side
	task automatic boot(input logic [2:0] scheme, input logic chain_n);
		I_RESETN = 1'b0;
		I_SCHEME = scheme;
		I_CHAIN_ENABLE_IN_N = chain_n;
		fork
			cyc(10);
			i_src.pulse(8);
		join
		`CHK(command_mode, 1'b1, "command mode in reset")
		`CHK(user_mode, 1'b0, "user mode in reset")
		`CHK(io_oe_n, 1'b1, "pins driven in reset")
		`CHK(user_reset_n, 1'b0, "user logic free in reset")
		`CHK(config_done, 1'b0, "done kept over reset")
		`CHK(chain_out_n, 1'b1, "chain out in reset")
		I_RESETN = 1'b1;
	endtask

	task automatic load(input logic [2:0] scheme, input logic [31:0] base);
		// the link sees ready two shift edges late and takes data from the third edge
		i_src.pulse(2);
		for (int w = 0; w < WORDS; w++)
			i_src.send(scheme, img(base, w));
		wait_on(1, 20, n);
		`CHK(chain_out_n, 1'b0, "chain out after load")
		wait_on(2, 12, n);
		`CHK(io_oe_n, 1'b0, "pins not enabled")
		`CHK(user_reset_n, 1'b1, "user reset held")
		`CHK(command_mode, 1'b0, "command mode in user")
		for (int w = 0; w < WORDS; w++)
		begin
			I_CFG_RD_ADDR = 2'(w);
			cyc(2);
			`CHK(rd_data, img(base, w), "stored word")
		end
		$display("image loaded, scheme %0d", scheme);
	endtask

	task automatic t_scheme(input logic [2:0] scheme);
		boot(scheme, 1'b0);
		wait_on(0, 1100, n);
		`CHK(n <= cms_pkg::POR_CYCLES + 3, 1'b1, "clear too long")
		`CHK(n >= cms_pkg::POR_CYCLES, 1'b1, "clear too short")
		`CHK(io_oe_n, 1'b1, "pins driven before load")
		load(scheme, 32'h9e37_0000 | 32'(scheme));
	endtask

	task automatic t_reconfig();
		realtime t0;
		t0 = $realtime;
		I_RECONFIG_N = 1'b0;
		// the link only notices that loading ended on its own edges, so clear it out here
		fork
			cyc(4);
			i_src.pulse(4);
		join
		`CHK(command_mode, 1'b1, "no command mode")
		`CHK(io_oe_n, 1'b1, "pins driven in reload")
		`CHK(user_reset_n, 1'b0, "user logic free")
		`CHK(config_done, 1'b0, "done kept")
		`CHK(chain_out_n, 1'b1, "chain out kept")
		I_RECONFIG_N = 1'b1;
		wait_on(0, 6, n);
		load(3'h4, 32'h5a1c_3e07);
		`CHK($realtime - t0 < 320.0e6, 1'b1, "reload too slow")
		$display("reconfiguration done");
	endtask

	task automatic t_chain();
		boot(3'h1, 1'b1);
		cyc(1010);
		`CHK(ready, 1'b0, "ready while chain off")
		for (int w = 0; w < WORDS; w++)
			i_src.send(3'h1, img(32'hdead_0001, w));
		cyc(20);
		`CHK(config_done, 1'b0, "data taken while chain off")
		`CHK(chain_out_n, 1'b1, "chain out early")
		I_CHAIN_ENABLE_IN_N = 1'b0;
		wait_on(0, 6, n);
		load(3'h1, 32'h0bad_c0fe);
		$display("chain enable done");
	endtask

	initial
	begin
		I_RESETN = 1'b0;
		I_SCHEME = 3'h0;
		I_RECONFIG_N = 1'b1;
		I_CHAIN_ENABLE_IN_N = 1'b0;
		I_CFG_RD_ADDR = 2'h0;
		#1;
		for (int s = 0; s < 5; s++)
			t_scheme(3'(s));
		t_reconfig();
		t_chain();
		end_sim();
	end
endmodule
`default_nettype wire
